// File: hdl/codec_clk_pkg.sv
// Functional notes
// - Playback rate code in bits 3..0; 0000 divides by one, up to six, 1011+ reserved.
// - Multiplier enable is bit 7 of control A; reset keeps it off.
// - Alternate divider bits 6..3; codes 0 and 1 mean 16 and 17; reset 0010.
// - Reference divider bits 2..0; code 000 means eight; reset 000.
// - Integer multiplier bits 7..2, range 1..63, reset 1; zero code reserved.
// - Fraction is 14 bits: upper eight in high register, lower six in low.
// - Low two bits of fraction low register read as 00.
// - Datapath bit 7 picks base rate: 0 is 48 kHz, 1 is 44.1 kHz.
// - Datapath bit 5 enables playback dual-rate; reset clear.
// - Left path source bits 4..3: mute, left, right, mono mix.
// - Right path source bits 2..1: mute, right, left, mono mix.
// - Record rate code in bits 7..4, same divider coding as playback.
// - Addresses 1..127 reach the active page; page zero after reset.
package codec_clk_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [6:0] ADDR_PAGE        = 7'h00;
    localparam logic [6:0] ADDR_RATE_SELECT = 7'h02;
    localparam logic [6:0] ADDR_MULT_CTRL_A = 7'h03;
    localparam logic [6:0] ADDR_MULT_INT    = 7'h04;
    localparam logic [6:0] ADDR_MULT_FRAC_H = 7'h05;
    localparam logic [6:0] ADDR_MULT_FRAC_L = 7'h06;
    localparam logic [6:0] ADDR_DATAPATH    = 7'h07;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_RATE_SELECT = 8'h00;
    localparam logic [7:0] RST_MULT_CTRL_A = 8'h10;
    localparam logic [7:0] RST_MULT_INT    = 8'h04;
    localparam logic [7:0] RST_MULT_FRAC_H = 8'h00;
    localparam logic [7:0] RST_MULT_FRAC_L = 8'h00;
    localparam logic [7:0] RST_DATAPATH    = 8'h00;

    // ****************************************
    // Field positions and codes
    // ****************************************
    localparam int         MULT_EN_BIT     = 7;
    localparam int         BASE_RATE_BIT   = 7;
    localparam int         REC_DUAL_BIT    = 6;
    localparam int         PLAY_DUAL_BIT   = 5;
    localparam logic [3:0] RATE_CODE_MAX   = 4'hA;
    localparam logic [7:0] FRAC_L_MASK     = 8'hFC;
    localparam logic [7:0] INT_MASK        = 8'hFC;
    localparam logic [7:0] DATAPATH_MASK   = 8'hFE;

    typedef enum logic [1:0] {
        SRC_MUTE  = 2'h0,
        SRC_SAME  = 2'h1,
        SRC_SWAP  = 2'h2,
        SRC_MONO  = 2'h3
    } path_src_e;

    typedef struct packed {
        logic        mulEnable;
        logic [4:0]  altDivide;
        logic [3:0]  refDivide;
        logic [5:0]  intMult;
        logic [13:0] fracMult;
    } mult_cfg_s;

    typedef struct packed {
        logic [2:0]  playDivide;
        logic [2:0]  recDivide;
        logic        base_rate_selection;
        logic        recDualRate;
        logic        playDualRate;
        path_src_e   leftSrc;
        path_src_e   rightSrc;
    } path_cfg_s;

endpackage

// File: hdl/codec_clock_datapath_config.sv
`timescale 1ns/100ps
module codec_clock_datapath_config
    import codec_clk_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [6:0] regAddr,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    output logic            regRvalid,
    output mult_cfg_s       multCfg,
    output path_cfg_s       pathCfg
);

    // ****************************************
    // Decode helpers
    // ****************************************
    // Rate code to divide factor; reserved codes hold the largest divide
    function automatic logic [2:0] rateDivide(input logic [3:0] code);
        logic [2:0] f;
        f = 3'h1;
        if (code > RATE_CODE_MAX) begin
            f = 3'h6;
        end else begin
            if (code == 4'h0) begin
                f = 3'h1;
            end else if (code <= 4'h3) begin
                f = 3'h2;
            end else if (code <= 4'h5) begin
                f = 3'h3;
            end else if (code <= 4'h8) begin
                f = 3'h4;
            end else if (code <= 4'h9) begin
                f = 3'h5;
            end else begin
                f = 3'h6;
            end
        end
        return f;
    endfunction

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic       page;
        logic [7:0] rate;
        logic [7:0] ctrlA;
        logic [7:0] intReg;
        logic [7:0] fracH;
        logic [7:0] fracL;
        logic [7:0] datapath;
        logic [7:0] rdata;
        logic       rvalid;
        mult_cfg_s  mult;
        path_cfg_s  path;
    } state_s;

    state_s state_q;
    state_s state_d;
    logic   page0Hit;

    always_comb begin
        state_d = state_q;
        state_d.rvalid = 1'b0;
        page0Hit = !state_q.page && (regAddr != ADDR_PAGE);
        if (regWrite) begin
            if (regAddr == ADDR_PAGE) begin
                state_d.page = regWdata[0];
            end else if (page0Hit) begin
                unique case (regAddr)
                    ADDR_RATE_SELECT: state_d.rate = regWdata;
                    ADDR_MULT_CTRL_A: state_d.ctrlA = regWdata;
                    // integer with reserved low bits dropped
                    ADDR_MULT_INT:    state_d.intReg = regWdata & INT_MASK;
                    ADDR_MULT_FRAC_H: state_d.fracH = regWdata;
                    ADDR_MULT_FRAC_L: state_d.fracL = regWdata & FRAC_L_MASK;
                    ADDR_DATAPATH:    state_d.datapath = regWdata & DATAPATH_MASK;
                    default: ;
                endcase
            end
        end
        if (regRead) begin
            state_d.rvalid = 1'b1;
            state_d.rdata = 8'h00;
            if (regAddr == ADDR_PAGE) begin
                state_d.rdata = {7'h00, state_q.page};
            end else if (page0Hit) begin
                unique case (regAddr)
                    ADDR_RATE_SELECT: state_d.rdata = state_q.rate;
                    ADDR_MULT_CTRL_A: state_d.rdata = state_q.ctrlA;
                    ADDR_MULT_INT:    state_d.rdata = state_q.intReg;
                    ADDR_MULT_FRAC_H: state_d.rdata = state_q.fracH;
                    ADDR_MULT_FRAC_L: state_d.rdata = state_q.fracL;
                    ADDR_DATAPATH:    state_d.rdata = state_q.datapath;
                    default:          state_d.rdata = 8'h00;
                endcase
            end
        end

        // ****************************************
        // Decoded configuration
        // ****************************************
        // multiplier enable
        state_d.mult.mulEnable = state_d.ctrlA[MULT_EN_BIT];
        // alternate divider, 0 and 1 map to 16 and 17
        state_d.mult.altDivide = (state_d.ctrlA[6:4] == 3'h0 && state_d.ctrlA[3] == 1'b0) ? 5'h10 :
                                 (state_d.ctrlA[6:3] == 4'h1) ? 5'h11 : {1'b0, state_d.ctrlA[6:3]};
        state_d.mult.refDivide = (state_d.ctrlA[2:0] == 3'h0) ? 4'h8 : {1'b0, state_d.ctrlA[2:0]};
        state_d.mult.intMult = state_d.intReg[7:2];
        // fraction applied only when the low half lands
        if (regWrite && page0Hit && regAddr == ADDR_MULT_FRAC_L) begin
            state_d.mult.fracMult = {state_q.fracH, regWdata[7:2]};
        end
        state_d.path.playDivide = rateDivide(state_d.rate[3:0]);
        state_d.path.recDivide = rateDivide(state_d.rate[7:4]);
        state_d.path.base_rate_selection = state_d.datapath[BASE_RATE_BIT];
        state_d.path.recDualRate = state_d.datapath[REC_DUAL_BIT];
        state_d.path.playDualRate = state_d.datapath[PLAY_DUAL_BIT];
        state_d.path.leftSrc = path_src_e'(state_d.datapath[4:3]);
        state_d.path.rightSrc = path_src_e'(state_d.datapath[2:1]);
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_q <= '0;
            state_q.rate <= RST_RATE_SELECT;
            state_q.ctrlA <= RST_MULT_CTRL_A;
            state_q.intReg <= RST_MULT_INT;
            state_q.fracH <= RST_MULT_FRAC_H;
            state_q.fracL <= RST_MULT_FRAC_L;
            state_q.datapath <= RST_DATAPATH;
            state_q.mult.altDivide <= 5'h02;
            state_q.mult.refDivide <= 4'h8;
            state_q.mult.intMult <= 6'h01;
            state_q.path.playDivide <= 3'h1;
            state_q.path.recDivide <= 3'h1;
        end else begin
            state_q <= state_d;
        end
    end

    assign regRdata  = state_q.rdata;
    assign regRvalid = state_q.rvalid;
    assign multCfg   = state_q.mult;
    assign pathCfg   = state_q.path;

endmodule

// File: tb/codec_clock_datapath_config_sva.sv
`timescale 1ns/100ps
module codec_clock_datapath_config_sva
    import codec_clk_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       resetn,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [6:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic       regRvalid,
    input wire mult_cfg_s  multCfg,
    input wire path_cfg_s  pathCfg
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Page is not a port, so the checker keeps its own copy
    logic pageQ;
    logic wOk;
    assign wOk = regWrite && !pageQ;
    always_ff @(posedge sys_clk) begin
        if (!resetn) pageQ <= 1'b0;
        else if (regWrite && regAddr == ADDR_PAGE) pageQ <= regWdata[0];
    end
    a_read_answer: assert property (regRead |=> regRvalid)
        else $error("read not answered");
    a_no_spurious: assert property (!regRead |=> !regRvalid)
        else $error("unrequested read answer");
    a_frac_atomic: assert property ((regWrite && regAddr != ADDR_MULT_FRAC_L) |=>
        $stable(multCfg.fracMult)) else $error("fraction changed without low write");
    a_frac_low: assert property ((wOk && regAddr == ADDR_MULT_FRAC_L) |=>
        multCfg.fracMult[5:0] == $past(regWdata[7:2])) else $error("fraction low bits wrong");
    a_mul_enable: assert property ((wOk && regAddr == ADDR_MULT_CTRL_A) |=>
        multCfg.mulEnable == $past(regWdata[7])) else $error("enable wrong");
    a_ref_div: assert property ((wOk && regAddr == ADDR_MULT_CTRL_A) |=> multCfg.refDivide ==
        (($past(regWdata[2:0]) == 3'h0) ? 4'h8 : {1'b0, $past(regWdata[2:0])}))
        else $error("reference divider wrong");
    a_alt_div: assert property ((wOk && regAddr == ADDR_MULT_CTRL_A) |=> multCfg.altDivide ==
        (($past(regWdata[6:4]) == 3'h0) ? {4'h8, $past(regWdata[3])} : {1'b0, $past(regWdata[6:3])}))
        else $error("alternate divider wrong");
    a_path_src: assert property ((wOk && regAddr == ADDR_DATAPATH) |=>
        pathCfg.leftSrc == $past(regWdata[4:3]) && pathCfg.rightSrc == $past(regWdata[2:1])
        && pathCfg.base_rate_selection == $past(regWdata[7])) else $error("path setup wrong");
    a_frac_rsvd: assert property ((regRead && !pageQ && regAddr == ADDR_MULT_FRAC_L) |=>
        regRdata[1:0] == 2'h0) else $error("reserved bits not zero");
    a_page_lock: assert property ((regWrite && pageQ && regAddr != ADDR_PAGE) |=>
        $stable(multCfg) && $stable(pathCfg)) else $error("page one write reached page zero");
endmodule
bind codec_clock_datapath_config codec_clock_datapath_config_sva chk_i (.sys_clk(sys_clk),
    .resetn(resetn), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid), .multCfg(multCfg),
    .pathCfg(pathCfg));

// File: tb/codec_clock_datapath_config_tb.sv
`timescale 1ns/100ps
module codec_clock_datapath_config_tb
    import codec_clk_pkg::*;
;
    logic       sys_clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic [6:0] regAddr = 7'h00;
    logic [7:0] regWdata = 8'h00, regRdata;
    logic       regRvalid;
    mult_cfg_s  multCfg;
    path_cfg_s  pathCfg;
    int         miscompares = 0, cmp_count = 0;
    codec_clock_datapath_config uut (.sys_clk(sys_clk), .resetn(resetn), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .regRvalid(regRvalid), .multCfg(multCfg), .pathCfg(pathCfg));
    initial forever #50 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Idle cycle after each access keeps strobes from being set twice in one step
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        @(posedge sys_clk) #10;
        regWrite = 1'b0;
        @(posedge sys_clk) #10;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        regRead = 1'b1;
        regAddr = a;
        @(posedge sys_clk) #10;
        regRead = 1'b0;
        chk({regRvalid, regRdata}, {1'b1, exp});
        @(posedge sys_clk) #10;
    endtask
    task automatic t_reset();
        logic [7:0] rv [6] = '{8'h00, 8'h10, 8'h04, 8'h00, 8'h00, 8'h00};
        chk(multCfg, {1'h0, 5'h02, 4'h8, 6'h01, 14'h0000});
        chk(pathCfg, {3'h1, 3'h1, 7'h00});
        for (int i = 0; i < 6; i++) rd(7'(i + 2), rv[i]);
        rd(7'h50, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_rate();
        logic [3:0] c [7] = '{4'h0, 4'h3, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB};
        logic [2:0] e [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h6};
        for (int i = 0; i < 7; i++) begin
            wr(ADDR_RATE_SELECT, {c[6 - i], c[i]});
            chk({pathCfg.playDivide, pathCfg.recDivide}, {e[i], e[6 - i]});
        end
        $display("t_rate done");
    endtask
    task automatic t_mult();
        logic [7:0] d;
        for (int i = 0; i < 16; i++) begin
            d = {i[0], i[3:0], i[2:0]};
            wr(ADDR_MULT_CTRL_A, d);
            chk({multCfg.mulEnable, multCfg.altDivide}, {i[0], (i < 2) ? 5'(16 + i) : 5'(i)});
            chk(multCfg.refDivide, (i[2:0] == 0) ? 4'h8 : {1'b0, i[2:0]});
            rd(ADDR_MULT_CTRL_A, d);
        end
        wr(ADDR_MULT_INT, 8'hFC);
        chk(multCfg.intMult, 6'h3F);
        rd(ADDR_MULT_INT, 8'hFC);
        wr(ADDR_MULT_FRAC_H, 8'h9C);
        chk(multCfg.fracMult, 14'h0000);
        wr(ADDR_MULT_FRAC_L, 8'h3F);
        chk(multCfg.fracMult, 14'h270F);
        rd(ADDR_MULT_FRAC_L, 8'h3C);
        $display("t_mult done");
    endtask
    task automatic t_path();
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_DATAPATH, {i[0], i[0], i[0], i[1:0], ~i[1:0], 1'b0});
            chk(pathCfg[6:0], {i[0], i[0], i[0], i[1:0], ~i[1:0]});
        end
        $display("t_path done");
    endtask
    task automatic t_page();
        wr(ADDR_PAGE, 8'h01);
        rd(ADDR_PAGE, 8'h01);
        wr(ADDR_MULT_CTRL_A, 8'h55);
        rd(ADDR_MULT_CTRL_A, 8'h00);
        wr(ADDR_PAGE, 8'h00);
        rd(ADDR_MULT_CTRL_A, 8'hFF);
        $display("t_page done");
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        #10;
        resetn = 1'b1;
        t_reset();
        t_rate();
        t_mult();
        t_path();
        t_page();
        // Mid-run reset from page one must bring back page zero and reset images
        wr(ADDR_PAGE, 8'h01);
        resetn = 1'b0;
        repeat (2) @(posedge sys_clk);
        #10;
        resetn = 1'b1;
        t_reset();
        test_done();
    end
endmodule
